// *** hw/flash_ctl_pkg.sv ***
// constants for the flash command controller
package flash_ctl_pkg;
  // wishbone register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0; // command and go
  localparam logic [3:0] REG_ADDR = 4'h4; // flash address
  localparam logic [3:0] REG_DATA = 4'h8; // write data / read result
  localparam logic [3:0] REG_STAT = 4'hC; // busy and status
  // flash address and data widths
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  // command data values
  localparam logic [7:0] D_UNLOCK1 = 8'hAA;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] D_RESET = 8'hF0;
  localparam logic [7:0] D_ID = 8'h90;
  localparam logic [7:0] D_SETUP = 8'h80;
  localparam logic [7:0] D_CHIP = 8'h10;
  localparam logic [7:0] D_SECTOR = 8'h30;
  localparam logic [7:0] D_SUSPEND = 8'hB0;
  localparam logic [7:0] D_PROGRAM = 8'hA0;
  localparam logic [7:0] D_PROT_UNLOCK = 8'h20;
  // unlock address patterns on the low eleven bits
  localparam logic [10:0] A_UNLOCK1 = 11'h555;
  localparam logic [10:0] A_UNLOCK2 = 11'h2AA;
  // status bit positions on the data pins
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  localparam int WINDOW_BIT = 3;
  // pin timing in ns and us and derived cycles at 250 MHz
  localparam int CLK_NS = 4;
  localparam int T_STROBE_NS = 100;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_LOAD_US = 30;
  localparam int LOAD_CYC = (T_LOAD_US * 1000) / CLK_NS;
  // order codes written to the control register
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_ID, OP_CHIP_ERASE, OP_SECTOR_ERASE,
    OP_SECTOR_ADD, OP_SUSPEND, OP_RESUME, OP_PROGRAM, OP_PROT_UNLOCK,
    OP_POLL
  } op_t;
endpackage : flash_ctl_pkg

// *** hw/flash_ctl.sv ***
// host side controller driving the flash command pins
`timescale 1ns/10ps
// Behaviour
// R1: reset command returns flash to reads
// R2: reset value aborts failed operation
// R3: id read uses addr bit1/bit0
// R4: high voltage id read mode
// R5: chip erase takes six writes
// R6: device preprograms then erases chip
// R7: erase starts at final strobe rise
// R8: chip erase done when poll bit one
// R9: erase ends by itself, no verify
// R10: timeout flag shows erase failure
// R11: sector erase six writes, sector address
// R12: address at strobe fall, data rise
// R13: sector registered on sixth falling edge
// R14: next sector write within load window
// R15: other commands in window abort erase
// R16: sector erase done: poll one, toggle still
// R17: suspend only during sector erase
// R18: suspend in window ends window
// R19: suspended device accepts few commands
// R20: suspend program reports normal status
// R21: protect verify returns protected code
// R22: high voltage protect pin levels
// R23: protect unlock before low voltage protect
// R24: data pins floating when not reading
// R25: unlock patterns on low eleven bits
// R26: toggle bit alternates while busy
// R27: window flag low while window open
module flash_ctl
  import flash_ctl_pkg::*;
#(
  parameter int LOAD_WINDOW_CYC = LOAD_CYC // sector load window
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // flash pins
  output logic [flash_ctl_pkg::ADDR_W-1:0] addr_o,
  input wire logic [flash_ctl_pkg::DATA_W-1:0] data_pins_i,
  output logic [flash_ctl_pkg::DATA_W-1:0] data_pins_o,
  output logic data_pins_oe_o,
  output logic chip_enable_n_o,
  output logic output_enable_n_o,
  output logic write_strobe_n_o,
  output logic id_high_voltage_o, // raise id select line to high voltage
  output logic oe_high_voltage_o // raise output enable to high voltage
);
  import flash_ctl_pkg::*;

  // refuse a window that the 16-bit timer cannot hold
  if (LOAD_WINDOW_CYC < 1 || LOAD_WINDOW_CYC > 65535)
  begin : g_bad_window
    $error("LOAD_WINDOW_CYC out of range");
  end

  // reset release synchroniser
  logic rst_s1_r, rst_n;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // data pin input synchroniser
  logic [7:0] din_s1_r, din_r;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      din_s1_r <= 8'h00;
      din_r <= 8'h00;
    end
    else
    begin
      din_s1_r <= data_pins_i;
      din_r <= din_s1_r;
    end
  end

  // software registers
  logic [3:0] op_r; // order code
  logic hv_r; // use high voltage pin modes
  logic [16:0] fa_r; // flash address
  logic [7:0] wd_r; // write data
  logic [7:0] rd_r; // last read byte
  logic busy_r; // sequence running
  logic go; // start pulse from bus
  logic prev_tog_r; // toggle bit of previous poll
  logic done_r; // erase finished flag
  logic win_open_r; // sector window still open

  // bus slave: ack one cycle after strobe, dropped next cycle
  assign go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
              && wb_adr_i == REG_CTRL && wb_sel_i[0] && !busy_r;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      op_r <= 4'h0;
      hv_r <= 1'b0;
      fa_r <= 17'h0_0000;
      wd_r <= 8'h00;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i)
      begin
        // writes while busy to ctrl are dropped
        if (go)
        begin
          op_r <= wb_dat_i[3:0];
          hv_r <= wb_dat_i[4];
        end
        if (wb_adr_i == REG_ADDR && !busy_r)
          fa_r <= wb_dat_i[16:0];
        if (wb_adr_i == REG_DATA && wb_sel_i[0] && !busy_r)
          wd_r <= wb_dat_i[7:0];
      end
      // read mux, unmapped reads zero
      unique case (wb_adr_i)
        REG_CTRL: wb_dat_o <= {27'h0, hv_r, op_r};
        REG_ADDR: wb_dat_o <= {15'h0, fa_r};
        REG_DATA: wb_dat_o <= {24'h0, rd_r};
        REG_STAT: wb_dat_o <= {28'h0, win_open_r, done_r, prev_tog_r,
                               busy_r};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // sequencer: list of bus cycles per order
  typedef enum {S_IDLE, S_SETUP, S_LOW, S_HIGH, S_NEXT} seq_t;
  seq_t st_r;
  logic [2:0] idx_r; // cycle index within order
  logic [2:0] ncyc; // cycles in order
  logic cyc_wr; // current cycle is a write
  logic [16:0] cyc_a; // current address
  logic [7:0] cyc_d; // current data
  logic [7:0] tmr_r; // strobe width counter

  // unlock prefix then order specific tail
  always_comb
  begin
    ncyc = 3'd1;
    cyc_wr = 1'b1;
    cyc_a = {6'h00, (idx_r[0] ? A_UNLOCK2 : A_UNLOCK1)}; // R25
    cyc_d = idx_r[0] ? D_UNLOCK2 : D_UNLOCK1;
    if (idx_r == 3'd2)
      cyc_d = D_SETUP;
    unique case (op_t'(op_r))
      OP_RESET:
      begin
        cyc_a = fa_r;
        cyc_d = D_RESET; // R1 R2 R15
      end
      OP_ID:
      begin
        ncyc = 3'd3;
        if (idx_r == 3'd2)
          cyc_d = D_ID;
      end
      OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_PROT_UNLOCK:
      begin
        ncyc = 3'd6; // R5 R11
        // second unlock pair repeats the first, three cycles later
        if (idx_r == 3'd3)
        begin
          cyc_a = {6'h00, A_UNLOCK1}; // R25
          cyc_d = D_UNLOCK1;
        end
        if (idx_r == 3'd4)
        begin
          cyc_a = {6'h00, A_UNLOCK2}; // R25
          cyc_d = D_UNLOCK2;
        end
        if (idx_r == 3'd5)
        begin
          cyc_a = {6'h00, A_UNLOCK1};
          cyc_d = (op_r == OP_CHIP_ERASE) ? D_CHIP :
                  (op_r == OP_SECTOR_ERASE) ? D_SECTOR : D_PROT_UNLOCK;
          if (op_r == OP_SECTOR_ERASE)
            cyc_a = fa_r; // R11 R13
        end
      end
      OP_SECTOR_ADD, OP_RESUME:
      begin
        cyc_a = fa_r;
        cyc_d = D_SECTOR; // R14 R19
      end
      OP_SUSPEND:
      begin
        cyc_a = fa_r;
        cyc_d = D_SUSPEND; // R17 R18
      end
      OP_PROGRAM:
      begin
        ncyc = 3'd4;
        if (idx_r == 3'd2)
          cyc_d = D_PROGRAM;
        if (idx_r == 3'd3)
        begin
          cyc_a = fa_r;
          cyc_d = wd_r; // R20
        end
      end
      default:
      begin
        // plain read or status poll
        cyc_wr = 1'b0;
        cyc_a = fa_r;
      end
    endcase
  end

  // pin sequencing, address set before strobe falls
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= S_IDLE;
      idx_r <= 3'd0;
      tmr_r <= 8'h00;
      busy_r <= 1'b0;
      rd_r <= 8'h00;
      addr_o <= 17'h0_0000;
      data_pins_o <= 8'h00;
      data_pins_oe_o <= 1'b0;
      chip_enable_n_o <= 1'b1;
      output_enable_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      id_high_voltage_o <= 1'b0;
      oe_high_voltage_o <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        S_IDLE:
        begin
          idx_r <= 3'd0;
          if (go)
          begin
            busy_r <= 1'b1;
            st_r <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          addr_o <= cyc_a; // R12
          data_pins_o <= cyc_d;
          chip_enable_n_o <= 1'b0;
          // hv read gives id/protect code, R4 R21
          id_high_voltage_o <= hv_r;
          // hv protect mode: oe at high voltage, R22
          oe_high_voltage_o <= hv_r && cyc_wr;
          tmr_r <= 8'h00;
          st_r <= S_LOW;
        end
        S_LOW:
        begin
          if (cyc_wr)
          begin
            write_strobe_n_o <= 1'b0; // R12
            data_pins_oe_o <= 1'b1;
          end
          else
          begin
            data_pins_oe_o <= 1'b0; // R24
            output_enable_n_o <= 1'b0;
          end
          tmr_r <= tmr_r + 8'd1;
          if (tmr_r == 8'(STROBE_CYC))
          begin
            tmr_r <= 8'h00;
            st_r <= S_HIGH;
          end
        end
        S_HIGH:
        begin
          // take the byte once, before released pins settle elsewhere
          if (!cyc_wr && tmr_r == 8'h00)
            rd_r <= din_r; // R3 R8
          write_strobe_n_o <= 1'b1; // R7 R12
          output_enable_n_o <= 1'b1;
          tmr_r <= tmr_r + 8'd1;
          if (tmr_r == 8'd2)
            st_r <= S_NEXT;
        end
        S_NEXT:
        begin
          data_pins_oe_o <= 1'b0; // R24
          chip_enable_n_o <= 1'b1;
          id_high_voltage_o <= 1'b0;
          oe_high_voltage_o <= 1'b0;
          if (idx_r + 3'd1 < ncyc)
          begin
            idx_r <= idx_r + 3'd1;
            st_r <= S_SETUP;
          end
          else
          begin
            busy_r <= 1'b0;
            st_r <= S_IDLE;
          end
        end
      endcase
    end
  end

  // poll tracking: done when poll bit one and toggle still
  logic poll_end;
  assign poll_end = st_r == S_NEXT && !cyc_wr;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_tog_r <= 1'b0;
      done_r <= 1'b0;
      win_open_r <= 1'b0;
    end
    else if (go)
      done_r <= 1'b0;
    else if (poll_end)
    begin
      prev_tog_r <= rd_r[TOGGLE_BIT]; // R26
      // a timed-out erase keeps the poll bit low, so it never reads done
      done_r <= rd_r[POLL_BIT]
                && rd_r[TOGGLE_BIT] == prev_tog_r; // R6 R8 R9 R10 R16
      win_open_r <= !rd_r[WINDOW_BIT]; // R27
    end
  end

  // sector window timer from last write strobe rise
  logic [15:0] win_cnt_r;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      win_cnt_r <= 16'h0000;
    else if (st_r == S_NEXT && cyc_wr)
      win_cnt_r <= 16'(LOAD_WINDOW_CYC); // R14
    else if (win_cnt_r != 16'h0000)
      win_cnt_r <= win_cnt_r - 16'd1;
  end

  a_strobe_width: assert property (@(posedge clk_i) disable iff (!rst_n)
    $fell(write_strobe_n_o) |-> !write_strobe_n_o [*8]) // R12
    else $error("write strobe too short");
  a_float_data: assert property (@(posedge clk_i) disable iff (!rst_n)
    !output_enable_n_o |-> !data_pins_oe_o) // R24
    else $error("data driven during read");
  a_ce_on_strobe: assert property (@(posedge clk_i) disable iff (!rst_n)
    !write_strobe_n_o |-> !chip_enable_n_o && output_enable_n_o) // R22
    else $error("strobe without chip enable");
  a_addr_stable: assert property (@(posedge clk_i) disable iff (!rst_n)
    !write_strobe_n_o && $past(!write_strobe_n_o) |-> $stable(addr_o))
    else $error("address moved in strobe"); // R12
  a_unlock_pat: assert property (@(posedge clk_i) disable iff (!rst_n)
    $fell(write_strobe_n_o) && data_pins_o == D_UNLOCK2 && op_r != OP_PROGRAM
    |-> addr_o[10:0] == A_UNLOCK2) // R25
    else $error("bad unlock address");
  a_sector_data: assert property (@(posedge clk_i) disable iff (!rst_n)
    $fell(write_strobe_n_o) && op_r == OP_SECTOR_ERASE && idx_r == 3'd5
    |-> data_pins_o == D_SECTOR && addr_o == fa_r) // R11
    else $error("bad sector command");
  a_chip_data: assert property (@(posedge clk_i) disable iff (!rst_n)
    $fell(write_strobe_n_o) && op_r == OP_CHIP_ERASE && idx_r == 3'd2
    |-> data_pins_o == D_SETUP) // R5
    else $error("bad setup value");
  // cycles spent on the current order, saturating
  logic [8:0] busy_cyc_r;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      busy_cyc_r <= 9'h000;
    else if (!busy_r)
      busy_cyc_r <= 9'h000;
    else if (busy_cyc_r != 9'h1FF)
      busy_cyc_r <= busy_cyc_r + 9'd1;
  end

  a_busy_start: assert property (@(posedge clk_i) disable iff (!rst_n) // R7
    go |=> busy_r)
    else $error("order not started");
  a_busy_end: assert property (@(posedge clk_i) disable iff (!rst_n) // R7
    busy_cyc_r <= 9'(6 * (STROBE_CYC + 7)))
    else $error("sequence hung");
  a_poll_done: assert property (@(posedge clk_i) disable iff (!rst_n)
    poll_end && !rd_r[POLL_BIT] |=> !done_r) // R8
    else $error("done while poll low");
  c_chip: cover property (@(posedge clk_i) $rose(busy_r)
    && op_r == OP_CHIP_ERASE);
  c_sector: cover property (@(posedge clk_i) $fell(busy_r)
    && op_r == OP_SECTOR_ERASE);
  c_done: cover property (@(posedge clk_i) $rose(done_r));
  c_susp: cover property (@(posedge clk_i) win_cnt_r != 16'h0000
    && st_r == S_SETUP && op_r == OP_SUSPEND);
endmodule : flash_ctl

// *** verif/flash_dev_model.sv ***
// behavioural flash device facing the command controller
`timescale 1ns/10ps
module flash_dev_model
  import flash_ctl_pkg::*;
#(
  parameter int WIN_NS = 800, // sector load window
  parameter int BUSY_RD = 4, // status reads before erase ends
  parameter logic [7:0] MAKER = 8'h3C, // arbitrary maker code
  parameter logic [7:0] DEVICE = 8'h4D // arbitrary device code
)(
  input wire logic [16:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic id_hv_i,
  output logic [7:0] data_o
);
  logic [2:0] mode = 3'd0; // 0 read 1 id 2 erase 3 window 4 suspended
  int step = 0; // unlock sequence position
  logic tog = 1'b0; // toggle bit state
  logic erased = 1'b0; // array erased
  logic sec = 1'b0; // erase is a sector erase
  logic drv = 1'b0; // data pins driven
  int left = 0; // reads until erase ends
  realtime t_win = 0; // last window write
  logic [16:0] alat = 17'h00000; // address latched at strobe fall
  initial data_o = 8'h00;
  // lapsed window starts the erase
  task lapse();
    if (mode == 3'd3 && $realtime - t_win > WIN_NS)
      mode = 3'd2;
  endtask : lapse
  // address latch
  always @(negedge we_n_i)
    if (!ce_n_i)
      alat = addr_i;
  // command decoder on strobe rise
  always @(posedge we_n_i)
    if (!ce_n_i)
    begin
      lapse();
      if (mode == 3'd3)
      begin
        if (data_i == D_SECTOR)
          t_win = $realtime;
        else
          mode = (data_i == D_SUSPEND) ? 3'd4 : 3'd0;
      end
      else if (mode == 3'd2)
      begin
        if (sec && data_i == D_SUSPEND)
          mode = 3'd4;
      end
      else if (mode == 3'd4)
      begin
        if (data_i == D_SECTOR)
          mode = 3'd2;
      end
      else if (data_i == D_RESET)
      begin
        mode = 3'd0;
        step = 0;
      end
      else if ((step == 0 || step == 3) && alat[10:0] == A_UNLOCK1
               && data_i == D_UNLOCK1)
        step++;
      else if ((step == 1 || step == 4) && alat[10:0] == A_UNLOCK2
               && data_i == D_UNLOCK2)
        step++;
      else if (step == 2 && data_i == D_SETUP)
        step = 3;
      else
      begin
        sec = data_i == D_SECTOR;
        left = BUSY_RD;
        t_win = $realtime;
        if (step == 2 && data_i == D_ID)
          mode = 3'd1;
        else if (step == 5 && (data_i == D_CHIP || sec))
          mode = sec ? 3'd3 : 3'd2;
        else
          mode = 3'd0;
        step = 0;
      end
    end
  // read cycle
  always @(negedge oe_n_i or negedge ce_n_i)
    if (!ce_n_i && !oe_n_i)
    begin
      lapse();
      drv = 1'b1;
      if (id_hv_i || mode == 3'd1)
        data_o = addr_i[1] ? 8'h00 : addr_i[0] ? DEVICE : MAKER;
      else if (mode == 3'd2 || mode == 3'd3)
      begin
        tog = ~tog;
        data_o = {1'b0, tog, 1'b0, 1'b0, mode == 3'd2, 3'b000};
        left = (mode == 3'd2) ? left - 1 : left;
        erased = erased | (left == 0);
        mode = (left == 0) ? 3'd0 : mode;
      end
      else
        data_o = erased ? 8'hFF : addr_i[7:0] ^ 8'hA5;
    end
  // released pins show a changing value
  always @(posedge oe_n_i or posedge ce_n_i)
    if (drv)
    begin
      data_o = ~data_o;
      drv = 1'b0;
    end
endmodule : flash_dev_model

// *** verif/flash_ctl_tb_top.sv ***
// self-checking bench for the flash command controller
`timescale 1ns/10ps
module flash_ctl_tb_top;
  import flash_ctl_pkg::*;
  localparam logic [7:0] MAKER_C = 8'h3C; // arbitrary maker code
  localparam logic [7:0] DEV_C = 8'h4D; // arbitrary device code
  logic clk_i = 1'b0, rst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, wb_ack_o, chk = 1'b0, dq_oe, ce_n, oe_n, we_n, idhv;
  logic oehv, hv_w = 1'b0; // high-voltage output enable, level at strobe
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [16:0] fa, ra;
  logic [7:0] dq_o, dq_m, dq, e, m;
  logic [7:0] exp_q[$], msk_q[$], idc[3];
  int err_total = 0, comparisons = 0, seed = 20830, cyc = 0;
  always #2 clk_i = ~clk_i;
  // wire level seen by both ends
  assign dq = dq_oe ? dq_o : dq_m;
  flash_ctl #(.LOAD_WINDOW_CYC(200)) flash_ctl_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .addr_o(fa), .data_pins_i(dq), .data_pins_o(dq_o),
    .data_pins_oe_o(dq_oe), .chip_enable_n_o(ce_n),
    .output_enable_n_o(oe_n), .write_strobe_n_o(we_n),
    .id_high_voltage_o(idhv), .oe_high_voltage_o(oehv));
  flash_dev_model #(.WIN_NS(800), .MAKER(MAKER_C), .DEVICE(DEV_C))
    flash_dev_model_i (.addr_i(fa), .data_i(dq), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .id_hv_i(idhv), .data_o(dq_m));
  // one classic wishbone cycle
  task automatic bus(input logic [3:0] a, input logic w,
                     input logic [31:0] d, input logic c);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    chk <= c;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk <= 1'b0;
  endtask : bus
  // checked register read
  task automatic check(input logic [3:0] a, input logic [7:0] ev, mv);
    exp_q.push_back(ev & mv);
    msk_q.push_back(mv);
    bus(a, 1'b0, 32'h0, 1'b1);
  endtask : check
  // start an order and wait until idle
  task automatic run(input op_t op, input logic hv, input logic [16:0] a);
    bus(REG_ADDR, 1'b1, {15'h0, a}, 1'b0);
    bus(REG_DATA, 1'b1, 32'h0, 1'b0);
    bus(REG_CTRL, 1'b1, {27'h0, hv, op}, 1'b0);
    do bus(REG_STAT, 1'b0, 32'h0, 1'b0); while (rd[0] !== 1'b0);
  endtask : run
  // poll until the erase ends, then status must have settled
  task automatic erase_end();
    do
    begin
      run(OP_POLL, 1'b0, ra);
      bus(REG_DATA, 1'b0, 32'h0, 1'b0);
    end
    while (rd[7] !== 1'b1);
    run(OP_POLL, 1'b0, ra);
    check(REG_DATA, 8'hFF, 8'hFF);
    run(OP_POLL, 1'b0, ra);
    check(REG_DATA, 8'hFF, 8'hFF);
    check(REG_STAT, 8'h06, 8'h0F);
  endtask : erase_end
  // high-voltage output enable seen during the last write strobe
  task automatic check_hv(input logic ev);
    comparisons++;
    if (hv_w !== ev)
    begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, hv_w, ev);
    end
  endtask : check_hv
  // level of the high-voltage output enable while strobe is low
  always @(posedge clk_i)
    if (we_n === 1'b0)
      hv_w <= oehv;
  // verdict and end of run
  task automatic wrap_up();
    $display("counts: %0d compared, %0d mismatched", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // compare each checked read with the oldest note
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && chk)
    begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      comparisons++;
      if ((wb_dat_o[7:0] & m) !== e)
      begin
        err_total++;
        $display("ERROR t=%0t got %h exp %h", $time, wb_dat_o[7:0] & m, e);
      end
    end
  // hang guard
  always @(posedge clk_i)
    if (++cyc > 60000)
    begin
      err_total++;
      wrap_up();
    end
  // main sequence
  initial
  begin
    idc = '{MAKER_C, DEV_C, 8'h00};
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    ra = 17'($random(seed));
    run(OP_RESET, 1'b0, ra);
    run(OP_READ, 1'b0, ra);
    check(REG_DATA, ra[7:0] ^ 8'hA5, 8'hFF);
    for (int i = 0; i < 3; i++)
    begin
      // the reset below leaves id mode, so enter it anew each pass
      run(OP_ID, 1'b0, 17'h0);
      run(OP_READ, 1'b0, 17'(i));
      if (i < 2)
        check(REG_DATA, idc[i], 8'hFF);
      run(OP_RESET, 1'b0, ra);
      run(OP_READ, 1'b1, 17'(i));
      check(REG_DATA, idc[i], 8'hFF);
    end
    $display("test id done");
    run(OP_SECTOR_ERASE, 1'b0, ra);
    run(OP_RESET, 1'b0, ra);
    run(OP_READ, 1'b0, ra);
    check(REG_DATA, ra[7:0] ^ 8'hA5, 8'hFF);
    run(OP_SUSPEND, 1'b0, ra);
    ra = 17'($random(seed));
    run(OP_READ, 1'b0, ra);
    check(REG_DATA, ra[7:0] ^ 8'hA5, 8'hFF);
    run(OP_SECTOR_ERASE, 1'b0, ra);
    run(OP_SUSPEND, 1'b0, ra);
    run(OP_READ, 1'b0, ra);
    check(REG_DATA, ra[7:0] ^ 8'hA5, 8'hFF);
    run(OP_PROGRAM, 1'b0, ra);
    run(OP_READ, 1'b0, ra);
    check(REG_DATA, ra[7:0] ^ 8'hA5, 8'hFF);
    run(OP_RESUME, 1'b0, ra);
    erase_end();
    $display("test suspend done");
    run(OP_SECTOR_ERASE, 1'b0, ra);
    run(OP_SECTOR_ADD, 1'b0, 17'($random(seed)));
    run(OP_POLL, 1'b0, ra);
    check(REG_DATA, 8'h00, 8'h88);
    check(REG_STAT, 8'h08, 8'h08);
    repeat (300) @(posedge clk_i);
    run(OP_POLL, 1'b0, ra);
    check(REG_DATA, 8'h08, 8'h88);
    erase_end();
    $display("test sector erase done");
    run(OP_CHIP_ERASE, 1'b0, ra);
    run(OP_POLL, 1'b0, ra);
    check(REG_DATA, 8'h08, 8'hA8);
    erase_end();
    $display("test chip erase done");
    run(OP_PROT_UNLOCK, 1'b0, ra);
    check_hv(1'b0);
    run(OP_RESET, 1'b1, ra);
    check_hv(1'b1);
    run(OP_READ, 1'b0, ra);
    check(REG_DATA, 8'hFF, 8'hFF);
    $display("test protect done");
    wrap_up();
  end
endmodule : flash_ctl_tb_top
